// file: rtl/cell_register_slice.sv
// How it works
// RULE_01: Eight elements act as latches or flops together; polarity from clock inversion.
// RULE_02: Ninth element is always an edge flop without front-end selection.
// RULE_03: One shared cell clock, optionally inverted for all elements at once.
// RULE_04: General element data comes from its LUT bit or direct bit.
// RULE_05: Unused data source ties the input to constant one or zero, zero default.
// RULE_06: Front-end mode lets the choose input pick LUT or direct data.
// RULE_07: One cell setting makes local set/clear synchronous or asynchronous.
// RULE_08: Synchronous set/clear either needs the enable or overrides it.
// RULE_09: Enable source and set/clear use chosen per low half, high half, ninth.
// RULE_10: Enable only affects flops; disabled flop holds its value at an edge.
// RULE_11: Enable, set/clear and choose inputs each have configurable inversion.
// RULE_12: Without any set/clear, elements capture or pass data normally.
// RULE_13: Global init acts asynchronously, forcing every element to its value.
// RULE_14: Each element's own bit picks set or clear for global and local.
// RULE_15: A cell option blocks global init once configuration is complete.
// RULE_16: Ninth flop data is carry input, one, zero, or carry-out.
// RULE_17: Synchronous set/clear changes flops only at the active clock edge.
`timescale 1ns/100ps
`include "cell_slice_regs.svh"
module cell_register_slice #(
  parameter int GEN_COUNT = 8,
  parameter int ADDR_W = 8
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Cell clock and controls
  input wire logic cell_clk_i,
  input wire logic clock_en_i,
  input wire logic alt_write_en_input_i,
  input wire logic local_set_clear_i,
  input wire logic front_sel_i,
  input wire logic global_init_n_i,
  // Cell data
  input wire logic [GEN_COUNT-1:0] lut_result_i,
  input wire logic [GEN_COUNT-1:0] direct_data_i,
  input wire logic carry_input_i,
  input wire logic carry_out_i,
  // Element outputs, ninth flop on top
  output logic [GEN_COUNT:0] q_o
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************

  // Field packing leaves room for eight general elements in an even split
  generate
    if (GEN_COUNT != 8) begin : g_bad_count
      $error("cell_register_slice supports exactly eight general elements");
    end
    if (ADDR_W < 5) begin : g_bad_addr
      $error("cell_register_slice needs at least five address bits");
    end
    // Packed configuration fields must fit one bus word
    if (`GRP_COUNT * `GRP_STRIDE > 32) begin : g_bad_group
      $error("cell_register_slice group fields overflow the bus word");
    end
    if (GEN_COUNT * `DSRC_STRIDE > 32) begin : g_bad_dsrc
      $error("cell_register_slice source fields overflow the bus word");
    end
  endgenerate

  localparam int HALF = GEN_COUNT / 2;

  // ***************************************************************
  // Configuration registers
  // ***************************************************************

  logic [`CTRL_WIDTH-1:0] ctrl;
  logic [`GRP_COUNT*`GRP_STRIDE-1:0] group_cfg;
  logic [GEN_COUNT:0] set_val;
  logic [GEN_COUNT*`DSRC_STRIDE-1:0] dsrc_cfg;

  logic bus_req;
  logic bus_wr;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] next_dat;
  logic hit_ctrl;
  logic hit_group;
  logic hit_setval;
  logic hit_dsrc;
  logic [31:0] ctrl_merged;
  logic [31:0] group_merged;
  logic [31:0] setval_merged;
  logic [31:0] dsrc_merged;

  // Byte lane merge of a write into an old word
  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // A fresh request is one not yet answered
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i;
  assign reg_addr = {wb_adr_i[ADDR_W-1:2], 2'b00};

  // Write strobes per word; status and unmapped addresses match none of them
  assign hit_ctrl = bus_wr && reg_addr == `REG_CTRL;
  assign hit_group = bus_wr && reg_addr == `REG_GROUP;
  assign hit_setval = bus_wr && reg_addr == `REG_SETVAL;
  assign hit_dsrc = bus_wr && reg_addr == `REG_DSRC;

  // Zero extension first, so the merge never sees bits above a narrow register
  assign ctrl_merged = merge_lanes(32'(ctrl), wb_dat_i, wb_sel_i);
  assign group_merged = merge_lanes(32'(group_cfg), wb_dat_i, wb_sel_i);
  assign setval_merged = merge_lanes(32'(set_val), wb_dat_i, wb_sel_i);
  assign dsrc_merged = merge_lanes(32'(dsrc_cfg), wb_dat_i, wb_sel_i);

  // Acknowledge one cycle after the request; it drops again in the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Control word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
    end else if (hit_ctrl) begin
      ctrl <= ctrl_merged[`CTRL_WIDTH-1:0];
    end
  end

  // Per-group enable source and set/clear use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      group_cfg <= `GROUP_RESET;
    end else if (hit_group) begin
      group_cfg <= group_merged[`GRP_COUNT*`GRP_STRIDE-1:0];
    end
  end

  // Per-element set or clear value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      set_val <= `SETVAL_RESET;
    end else if (hit_setval) begin
      set_val <= setval_merged[GEN_COUNT:0];
    end
  end

  // Per-element data source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dsrc_cfg <= `DSRC_RESET;
    end else if (hit_dsrc) begin
      dsrc_cfg <= dsrc_merged[GEN_COUNT*`DSRC_STRIDE-1:0];
    end
  end

  // ***************************************************************
  // Cell clock and control polarity
  // ***************************************************************

  logic clk_prev;
  logic clk_inv;
  logic active_edge;
  logic latch_open;
  logic ce_primary;
  logic ce_alt;
  logic lsr_level;
  logic choose;
  logic ginit;

  // Previous sample of the cell clock, for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Start from the pin's own level, so leaving reset never fakes an edge
      clk_prev <= cell_clk_i;
    end else begin
      clk_prev <= cell_clk_i;
    end
  end

  // Inversion swaps rising for falling edges and high for low transparency
  assign clk_inv = ctrl[`CTRL_CLK_INV];
  assign active_edge = clk_inv ? (clk_prev && !cell_clk_i) : (!clk_prev && cell_clk_i); // RULE_03
  assign latch_open = cell_clk_i ^ clk_inv; // RULE_03

  // Each control input may be made active low
  assign ce_primary = clock_en_i ^ ctrl[`CTRL_CE_INV]; // RULE_11
  assign ce_alt = alt_write_en_input_i ^ ctrl[`CTRL_CE_INV]; // RULE_11
  assign lsr_level = local_set_clear_i ^ ctrl[`CTRL_LSR_INV]; // RULE_11
  assign choose = front_sel_i ^ ctrl[`CTRL_SEL_INV]; // RULE_11

  // Global init is ignored once configuration is done and the cell opts out
  assign ginit = !global_init_n_i && !(ctrl[`CTRL_GINIT_OFF] && ctrl[`CTRL_CFG_DONE]); // RULE_15

  // ***************************************************************
  // Group enables and set/clear
  // ***************************************************************

  logic [`GRP_COUNT-1:0] grp_ce;
  logic [`GRP_COUNT-1:0] grp_lsr;

  // Low half, high half and ninth flop each pick their own sources
  generate
    for (genvar g = 0; g < `GRP_COUNT; g++) begin : g_group
      cell_slice_pkg::ce_src_t ce_src;
      assign ce_src = cell_slice_pkg::ce_src_t'(group_cfg[g*`GRP_STRIDE +: `GRP_CE_W]);
      // Missing enable means always enabled
      always_comb begin
        case (ce_src)
          cell_slice_pkg::CE_NONE: grp_ce[g] = 1'b1; // RULE_09
          cell_slice_pkg::CE_PRIMARY: grp_ce[g] = ce_primary; // RULE_09
          cell_slice_pkg::CE_ALT: grp_ce[g] = ce_alt; // RULE_09
          default: grp_ce[g] = 1'b1;
        endcase
      end
      assign grp_lsr[g] = lsr_level && group_cfg[g*`GRP_STRIDE+`GRP_LSR_BIT]; // RULE_09
    end
  endgenerate

  // ***************************************************************
  // General elements
  // ***************************************************************

  logic [GEN_COUNT-1:0] gen_d;

  generate
    for (genvar i = 0; i < GEN_COUNT; i++) begin : g_elem
      localparam int GRP = (i < HALF) ? 0 : 1;

      data_select u_sel (
        .src_i(cell_slice_pkg::dsrc_t'(dsrc_cfg[i*`DSRC_STRIDE +: `DSRC_STRIDE])),
        .lut_i(lut_result_i[i]),
        .direct_i(direct_data_i[i]),
        .choose_i(choose),
        .d_o(gen_d[i])
      );

      // Latch or flop choice is common to all eight
      storage_element u_elem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .latch_mode_i(ctrl[`CTRL_LATCH]),
        .edge_i(active_edge),
        .open_i(latch_open),
        .d_i(gen_d[i]),
        .ce_i(grp_ce[GRP]),
        .lsr_i(grp_lsr[GRP]),
        .lsr_async_i(ctrl[`CTRL_LSR_ASYNC]),
        .lsr_prio_i(ctrl[`CTRL_LSR_PRIO]),
        .ginit_i(ginit),
        .set_val_i(set_val[i]),
        .q_o(q_o[i])
      ); // RULE_01
    end
  endgenerate

  // ***************************************************************
  // Ninth flop
  // ***************************************************************

  cell_slice_pkg::ninth_src_t ninth_src;
  logic ninth_d;

  assign ninth_src = cell_slice_pkg::ninth_src_t'(ctrl[`CTRL_NINTH_HI:`CTRL_NINTH_LO]);

  // Limited source set; carry-out is meaningful in ripple and half-logic use
  always_comb begin
    case (ninth_src)
      cell_slice_pkg::N_ZERO: ninth_d = 1'b0; // RULE_16
      cell_slice_pkg::N_ONE: ninth_d = 1'b1; // RULE_16
      cell_slice_pkg::N_CARRY_IN: ninth_d = carry_input_i; // RULE_16
      cell_slice_pkg::N_CARRY_OUT: ninth_d = carry_out_i; // RULE_16
      default: ninth_d = 1'b0;
    endcase
  end

  // Never a latch, whatever the common mode says
  storage_element u_ninth (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .latch_mode_i(1'b0),
    .edge_i(active_edge),
    .open_i(1'b0),
    .d_i(ninth_d),
    .ce_i(grp_ce[`GRP_NINTH]),
    .lsr_i(grp_lsr[`GRP_NINTH]),
    .lsr_async_i(ctrl[`CTRL_LSR_ASYNC]),
    .lsr_prio_i(ctrl[`CTRL_LSR_PRIO]),
    .ginit_i(ginit),
    .set_val_i(set_val[GEN_COUNT]),
    .q_o(q_o[GEN_COUNT])
  ); // RULE_02

  // ***************************************************************
  // Read path
  // ***************************************************************

  // Unmapped addresses read as zero; the write side ignores them
  always_comb begin
    next_dat = `WORD_ZERO;
    case (reg_addr)
      `REG_CTRL: next_dat[`CTRL_WIDTH-1:0] = ctrl;
      `REG_GROUP: next_dat[`GRP_COUNT*`GRP_STRIDE-1:0] = group_cfg;
      `REG_SETVAL: next_dat[GEN_COUNT:0] = set_val;
      `REG_DSRC: next_dat[GEN_COUNT*`DSRC_STRIDE-1:0] = dsrc_cfg;
      `REG_STATUS: begin
        next_dat[GEN_COUNT:0] = q_o;
        next_dat[`STAT_GINIT] = ginit;
        next_dat[`STAT_LSR] = lsr_level;
      end
      default: next_dat = `WORD_ZERO;
    endcase
  end

  // Read data is registered with the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `WORD_ZERO;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= next_dat;
    end
  end

endmodule // cell_register_slice

// file: rtl/cell_slice_pkg.sv
package cell_slice_pkg;

  // Data source of a general element
  typedef enum logic [2:0] {
    SRC_ZERO,
    SRC_ONE,
    SRC_LUT,
    SRC_DIRECT,
    SRC_FRONT_SEL,
    SRC_SPARE5,
    SRC_SPARE6,
    SRC_SPARE7
  } dsrc_t;

  // Clock enable source of a group
  typedef enum logic [1:0] {CE_NONE, CE_PRIMARY, CE_ALT, CE_SPARE} ce_src_t;

  // Data source of the ninth flop
  typedef enum logic [1:0] {N_ZERO, N_ONE, N_CARRY_IN, N_CARRY_OUT} ninth_src_t;

endpackage

// file: rtl/cell_slice_regs.svh
`ifndef CELL_SLICE_REGS_SVH
`define CELL_SLICE_REGS_SVH

// Byte offsets of the configuration words
`define REG_CTRL 8'h00
`define REG_GROUP 8'h04
`define REG_SETVAL 8'h08
`define REG_DSRC 8'h0C
`define REG_STATUS 8'h10

// Control word fields
`define CTRL_LSR_ASYNC 0
`define CTRL_CLK_INV 1
`define CTRL_LSR_PRIO 2
`define CTRL_LATCH 3
`define CTRL_GINIT_OFF 4
`define CTRL_CE_INV 5
`define CTRL_LSR_INV 6
`define CTRL_SEL_INV 7
`define CTRL_CFG_DONE 8
`define CTRL_NINTH_LO 9
`define CTRL_NINTH_HI 10
`define CTRL_WIDTH 11

// Group word: three bits per group, enable source then local set/clear use
`define GRP_STRIDE 3
`define GRP_CE_W 2
`define GRP_LSR_BIT 2
`define GRP_COUNT 3
`define GRP_NINTH 2

// Data source word: three bits per general element
`define DSRC_STRIDE 3

// Status word fields above the element outputs
`define STAT_GINIT 9
`define STAT_LSR 10

// Reset values
`define CTRL_RESET 11'h000
`define GROUP_RESET 9'h000
`define SETVAL_RESET 9'h000
`define DSRC_RESET 24'h000000
`define WORD_ZERO 32'h00000000

`endif

// file: rtl/data_select.sv
`timescale 1ns/100ps
module data_select (
  // Configuration
  input wire cell_slice_pkg::dsrc_t src_i,
  // Candidate data
  input wire logic lut_i,
  input wire logic direct_i,
  input wire logic choose_i,
  // Chosen data
  output logic d_o
);

  // Source mux; spare codes fall back to the constant zero default
  always_comb begin
    case (src_i)
      cell_slice_pkg::SRC_ZERO: d_o = 1'b0; // RULE_05
      cell_slice_pkg::SRC_ONE: d_o = 1'b1; // RULE_05
      cell_slice_pkg::SRC_LUT: d_o = lut_i; // RULE_04
      cell_slice_pkg::SRC_DIRECT: d_o = direct_i; // RULE_04
      cell_slice_pkg::SRC_FRONT_SEL: d_o = choose_i ? direct_i : lut_i; // RULE_06
      default: d_o = 1'b0;
    endcase
  end

endmodule // data_select

// file: rtl/storage_element.sv
`timescale 1ns/100ps
module storage_element (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Mode and timing
  input wire logic latch_mode_i,
  input wire logic edge_i,
  input wire logic open_i,
  // Data and controls, polarity already resolved
  input wire logic d_i,
  input wire logic ce_i,
  input wire logic lsr_i,
  input wire logic lsr_async_i,
  input wire logic lsr_prio_i,
  input wire logic ginit_i,
  input wire logic set_val_i,
  // State
  output logic q_o
);

  // One bit of storage; global init outranks local set/clear, which outranks data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= 1'b0;
    end else if (ginit_i) begin
      q_o <= set_val_i; // RULE_13 RULE_14
    end else if (lsr_i && lsr_async_i) begin
      q_o <= set_val_i; // RULE_07 RULE_14
    end else if (latch_mode_i) begin
      // Transparent latch: no enable, follows data while open
      if (open_i) begin
        q_o <= lsr_i ? set_val_i : d_i; // RULE_01 RULE_12
      end
    end else if (edge_i) begin
      if (lsr_i && (lsr_prio_i || ce_i)) begin
        q_o <= set_val_i; // RULE_08 RULE_17
      end else if (ce_i) begin
        q_o <= d_i; // RULE_10 RULE_12
      end
    end
  end

endmodule // storage_element

// file: test/lut_carry_model.sv
`timescale 1ns/100ps
module lut_carry_model (
  // Operands from the routing
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic carry_input_i,
  // Results toward the storage stage
  output logic [7:0] lut_result_o,
  output logic carry_out_o
);
  // ****
  // Tables set up as a ripple adder
  // ****
  // Sum bits feed the elements, the top carry feeds the ninth flop
  assign {carry_out_o, lut_result_o} = {1'b0, a_i} + {1'b0, b_i} + 9'(carry_input_i);
endmodule // lut_carry_model

// file: test/slice_checker_properties.sv
`timescale 1ns/100ps
module slice_checker #(
  parameter int GEN_COUNT = 8,
  parameter int ADDR_W = 8
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Cell
  input wire logic cell_clk_i,
  input wire logic local_set_clear_i,
  input wire logic global_init_n_i,
  input wire logic [GEN_COUNT:0] q_o
);
  // ****
  // Configuration mirror
  // ****
  logic [10:0] ctrl;
  logic [8:0] grp;
  logic [8:0] setval;
  logic take, wr, wr_d, run, ginit, calm;
  int unsigned widx;
  assign widx = 32'(wb_adr_i[ADDR_W-1:2]);
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = take && wb_we_i;
  assign ginit = !global_init_n_i && !(ctrl[4] && ctrl[8]);
  // A fresh clock polarity may fake an edge, so quiet means no recent write
  assign calm = run && !wr && !wr_d && !ginit && !ctrl[0];
  // Byte lanes follow the select bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= '0;
      grp <= '0;
      setval <= '0;
    end else if (wr) begin
      if (widx == 0 && wb_sel_i[0]) ctrl[7:0] <= wb_dat_i[7:0];
      if (widx == 0 && wb_sel_i[1]) ctrl[10:8] <= wb_dat_i[10:8];
      if (widx == 1 && wb_sel_i[0]) grp[7:0] <= wb_dat_i[7:0];
      if (widx == 1 && wb_sel_i[1]) grp[8] <= wb_dat_i[8];
      if (widx == 2 && wb_sel_i[0]) setval[7:0] <= wb_dat_i[7:0];
      if (widx == 2 && wb_sel_i[1]) setval[8] <= wb_dat_i[8];
    end
  end
  // Edge history is stale in the first cycle after reset
  always_ff @(posedge clk_i) begin
    run <= !rst_i;
    wr_d <= wr && !rst_i;
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_answer_a: assert property (take |=> wb_ack_o)
    else $error("bus request not acknowledged");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  reset_clear_a: assert property ($fell(rst_i) |-> q_o == '0 && !wb_ack_o)
    else $error("state not cleared by reset");
  unmapped_zero_a: assert property (take && !wb_we_i && widx > 4 |=> wb_dat_o == '0)
    else $error("unmapped read not zero");
  ginit_force_a: assert property (
    ginit && !wr |=> q_o == setval) else $error("global init missed set values");
  hold_q_a: assert property (
    calm && !ctrl[3] && $stable(cell_clk_i) |=> $stable(q_o))
    else $error("flop changed without a cell edge");
  ninth_flop_a: assert property (
    calm && $stable(cell_clk_i) |=> $stable(q_o[8])) else $error("ninth flop acted as latch");
  async_clear_a: assert property (
    ctrl[0] && (local_set_clear_i ^ ctrl[6]) && grp[8] && !wr |=> q_o[8] == setval[8])
    else $error("async set/clear missed ninth flop");
endmodule // slice_checker
bind cell_register_slice slice_checker #(.GEN_COUNT(GEN_COUNT), .ADDR_W(ADDR_W))
  slice_checker_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .cell_clk_i, .local_set_clear_i, .global_init_n_i, .q_o);

// file: test/testbench.sv
`timescale 1ns/100ps
module testbench;
  // ****
  // Signals and instances
  // ****
  logic clk_i, rst_i, cyc, stb, we, ack, cclk, ce, alt, local_set_clear, fsel, gin_n, carry_input, cout, prev;
  logic [7:0] adr, a, b, lut;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, dat_o;
  logic [8:0] q, old;
  logic [31:0] shadow [4];
  int miscompares, checks;
  localparam logic [31:0] mask [4] = '{32'h000007FF, 32'h000001FF, 32'h000001FF, 32'h00FFFFFF};
  cell_register_slice cell_register_slice_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .cell_clk_i(cclk), .clock_en_i(ce),
    .alt_write_en_input_i(alt), .local_set_clear_i(local_set_clear), .front_sel_i(fsel),
    .global_init_n_i(gin_n), .lut_result_i(lut), .direct_data_i(b), .carry_input_i(carry_input),
    .carry_out_i(cout), .q_o(q));
  lut_carry_model lut_carry_model_inst (.a_i(a), .b_i(b), .carry_input_i(carry_input),
    .lut_result_o(lut), .carry_out_o(cout));
  // Free-running system clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ****
  // Tasks and expectations
  // ****
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [31:0] merge(logic [31:0] o, n, logic [3:0] s, logic [31:0] m);
    for (int i = 0; i < 4; i++)
      if (s[i]) o[8*i+:8] = n[8*i+:8];
    return o & m;
  endfunction
  function automatic logic [7:0] exp_src(int c, logic [7:0] l, d, logic ch);
    case (c)
      1: return 8'hFF;
      2: return l;
      3: return d;
      4: return ch ? d : l;
      default: return 8'h00;
    endcase
  endfunction
  // Classic single cycle; waits for ack however long it takes
  task automatic wb(logic w, logic [7:0] ad, logic [31:0] d, logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(int i, logic [31:0] d, logic [3:0] s = 4'hF);
    wb(1'b1, 8'(4 * i), d, s);
    shadow[i] = merge(shadow[i], d, s, mask[i]);
  endtask
  task automatic cfg(logic [31:0] c, g, d);
    wr(0, c);
    wr(1, g);
    wr(3, d);
  endtask
  // One active cell edge with fresh random data and controls
  task automatic tick();
    @(posedge clk_i);
    cclk <= shadow[0][1];
    a <= 8'($urandom());
    b <= 8'($urandom());
    {ce, alt, fsel, carry_input} <= 4'($urandom());
    @(posedge clk_i);
    cclk <= ~shadow[0][1];
    @(posedge clk_i);
    #1;
  endtask
  // Watchdog, far beyond the fewer than one thousand cycles expected
  initial begin
    #200us;
    miscompares++;
    give_verdict();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    void'($urandom(70));
    {cyc, stb, we, cclk, ce, alt, local_set_clear, fsel, carry_input, a, b, adr, sel, wdat} = '0;
    gin_n = 1'b1;
    rst_i = 1'b1;
    shadow = '{default: '0};
    miscompares = 0;
    checks = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, status and an unmapped word
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 8'(4 * i), '0, 4'hF);
      check("reset value", rdat, 32'h00000000);
    end
    // Random words and byte lanes read back
    for (int k = 0; k < 12; k++) begin
      wr(k % 4, $urandom(), 4'($urandom()));
      wb(1'b0, 8'(4 * (k % 4)), '0, 4'hF);
      check("config word", rdat, shadow[k % 4]);
    end
    // Every data and ninth source under both choose polarities, clock inverted for odd codes
    for (int c = 0; c < 16; c++) begin
      cfg(32'(c % 4) << 9 | 32'(c[0]) << 1 | 32'(c[3]) << 7, '0, {8{3'(c)}});
      tick();
      check("source", q[7:0], exp_src(c % 8, lut, b, fsel ^ shadow[0][7]));
      check("ninth source", q[8], c[1] ? (c[0] ? cout : carry_input) : 1'(c[0]));
    end
    // Per-group enables, with and without inversion
    for (int k = 0; k < 16; k++) begin
      cfg(32'h00000400 | 32'(k[3]) << 5, 32'h00000051, {8{3'h3}});
      old = q;
      tick();
      check("enable", q, {(ce ^ shadow[0][5]) ? carry_input : old[8],
        (alt ^ shadow[0][5]) ? b[7:4] : old[7:4], (ce ^ shadow[0][5]) ? b[3:0] : old[3:0]});
    end
    // Synchronous set/clear waits for an edge and obeys priority
    for (int k = 0; k < 8; k++) begin
      wr(2, $urandom());
      cfg(32'h00000400 | 32'(k[0]) << 2 | 32'(k[1]) << 6, 32'h0000016D, {8{3'h3}});
      @(posedge clk_i);
      local_set_clear <= ~shadow[0][6];
      old = q;
      repeat (3) @(posedge clk_i);
      #1;
      check("sync hold", q, old);
      wb(1'b0, 8'h10, '0, 4'hF);
      check("status lsr", rdat, {22'h000001, 1'b0, old});
      tick();
      check("sync lsr", q, (shadow[0][2] | ce ^ shadow[0][5]) ? shadow[2] : old);
      @(posedge clk_i);
      local_set_clear <= 1'b0;
    end
    // Asynchronous set/clear acts with no cell edge
    wr(2, $urandom());
    cfg(32'h00000401, 32'h0000016D, {8{3'h3}});
    @(posedge clk_i);
    local_set_clear <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    check("async lsr", q, shadow[2]);
    @(posedge clk_i);
    local_set_clear <= 1'b0;
    // Global init, blocked only when disabled after configuration
    for (int k = 0; k < 4; k++) begin
      wr(2, $urandom());
      cfg(32'h00000400 | 32'(k[0]) << 4 | 32'(k[1]) << 8, '0, {8{3'h3}});
      @(posedge clk_i);
      gin_n <= 1'b0;
      tick();
      old = (k == 3) ? {carry_input, b} : shadow[2][8:0];
      check("global init", q, old);
      wb(1'b0, 8'h10, '0, 4'hF);
      check("status init", rdat, {22'h000000, k != 3, old});
      @(posedge clk_i);
      gin_n <= 1'b1;
    end
    // Latch mode: general elements follow while open, ninth stays a flop
    cfg(32'h00000408, '0, {8{3'h3}});
    for (int k = 0; k < 8; k++) begin
      old = q;
      prev = cclk;
      @(posedge clk_i);
      cclk <= 1'($urandom());
      b <= 8'($urandom());
      carry_input <= 1'($urandom());
      repeat (2) @(posedge clk_i);
      #1;
      check("latch", q, {(cclk & ~prev) ? carry_input : old[8], cclk ? b : old[7:0]});
    end
    give_verdict();
  end
endmodule // testbench
